// *** smc_pkg.sv ***
// Package of constants and types for the stop mode controller.
// Function
// - STOP with permit set enters a stop mode; bus and CPU clocks halt.
// - STOP with permit clear enters no stop mode; forces illegal-opcode reset.
// - Deep stop only when powerdown select set; otherwise light stop.
// - Light stop puts regulator in standby; deep stop in partial powerdown.
// - Deep stop powers off most logic; RAM, oscillator, display, optional TIME_OF_DAY_UNIT stay.
// - Deep stop latches all pin controls; display pins keep driving waveforms.
// - Deep stop ends on low wake pin or enabled time-of-day wake.
// - Deep stop wake restarts as power-on; most registers reset, some kept.
// - Deep stop wake enables low-voltage reset; hold reset while supply low.
// - Deep stop wake sets powerdown flag until software writes acknowledge one.
// - Acknowledge opens the pin latches; port registers must be restored first.
// - Peripheral pins need peripheral re-enabled before acknowledge.
// - Light stop keeps all register, logic, RAM and pin states.
// - Light stop ends on reset pin or any listed interrupt source.
// - Pin reset exit takes reset vector; interrupt exit takes interrupt vector.
// - Debug enable keeps debug clocks and full regulation; deep becomes light.
// - While stopped, status memory commands access nothing and report error.
// - With debug enabled, background command wakes into active background mode.
// - Low-voltage detect and stop-enable both set keep regulator; deep becomes light.
// - No deep stop from low-power run; select and low-power run exclusive.
package smc_pkg;

  // Register offsets on the plain register port
  localparam logic [3:0] SMC_OFF_CTRL   = 4'h0;
  localparam logic [3:0] SMC_OFF_STATUS = 4'h1;
  localparam logic [3:0] SMC_OFF_ACK    = 4'h2;

  // Control register field positions
  localparam int SMC_CTRL_STOP_PERMIT = 0;
  localparam int SMC_CTRL_LVD_EN      = 1;
  localparam int SMC_CTRL_LVD_STOP_EN = 2;
  localparam int SMC_CTRL_PPD_SEL     = 3;
  localparam int SMC_CTRL_LPR         = 4;
  localparam int SMC_CTRL_TOD_WAKE_EN = 5;

  // Status register field positions
  localparam int SMC_STAT_PPD_FLAG  = 0;
  localparam int SMC_STAT_MODE_LO   = 1;
  localparam int SMC_STAT_MODE_HI   = 2;
  localparam int SMC_STAT_REG_LO    = 3;
  localparam int SMC_STAT_REG_HI    = 4;

  // Acknowledge register field position
  localparam int SMC_ACK_PPD = 0;

  // Reset values
  localparam logic [7:0] SMC_CTRL_RST = 8'h00;

  // Regulator state encoding
  localparam logic [1:0] SMC_REG_FULL    = 2'h0;
  localparam logic [1:0] SMC_REG_STANDBY = 2'h1;
  localparam logic [1:0] SMC_REG_PPD     = 2'h2;

  typedef enum logic [1:0] {
    SMC_RUN,
    SMC_LIGHT,
    SMC_DEEP,
    SMC_WAKE
  } smc_state_e;

endpackage : smc_pkg

// *** smc_stop_ctrl.sv ***
// Stop mode selection, entry and wake-up controller.
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module smc_stop_ctrl (
  input  wire logic       CLOCK,
  input  wire logic       RST,
  // Register port
  input  wire logic [3:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output var  logic [7:0] RDATA,
  // CPU and system inputs
  input  wire logic       STOP_EXEC,
  input  wire logic       DEBUG_MODE_ENABLE,
  input  wire logic       WAKE_RESET_PIN_N,
  input  wire logic       WAKE_PIN_DRIVEN_HIGH,
  input  wire logic       TOD_WAKE,
  input  wire logic       IRQ_WAKE,
  input  wire logic       BACKGROUND_CMD,
  input  wire logic       SUPPLY_LOW,
  input  wire logic       STATUS_CMD,
  // Control outputs
  output var  logic       CLK_HALT,
  output var  logic       DEBUG_CLK_RUN,
  output var  logic [1:0] REG_STATE,
  output var  logic       POWERDOWN,
  output var  logic       IO_LATCH,
  output var  logic       ILLEGAL_OP_RESET,
  output var  logic       POR_RESET,
  output var  logic       LVR_ENABLE,
  output var  logic       PIN_RESET_OUT,
  output var  logic       TAKE_IRQ_VECTOR,
  output var  logic       ENTER_BACKGROUND,
  output var  logic       STATUS_ERR
);

  // Overview of the controller
  // The CPU reports a STOP through a one-cycle pulse on STOP_EXEC.
  // The mode is chosen from the control bits standing at that edge,
  // so a control write in the same cycle as STOP is not yet seen.
  // Deep stop powers most logic down and needs a reset-like exit.
  // Light stop keeps every state and leaves on pin or interrupt.
  // Debug and low-voltage-in-stop both keep the regulator up, so a
  // deep request falls back to light stop in either case.
  // The pin latch stays closed after a deep wake until software
  // acknowledges; this gives software time to restore the ports.
  // The control register belongs to power management and so is
  // kept through a deep wake; only the core is reset then.
  // All outputs are registered, so each but the debug clocks follows the state by one
  // cycle; the flag and the latch follow their events by one cycle.
  // A STOP seen outside run is ignored: the CPU is not running then.
  // The wake state holds the core in reset while the supply is low;
  // run resumes only once the supply is back above the trip point.
  // Limitation: a pin reset from light stop only leaves the stop;
  // resetting the rest of the device is left to the reset logic.

  // Controller state and software-visible registers
  smc_pkg::smc_state_e state_q;
  smc_pkg::smc_state_e state_d;
  logic [7:0]          ctrl_q;
  logic                ppd_flag_q;
  // Decoded conditions
  logic                in_run;
  logic                in_light;
  logic                in_deep;
  logic                in_wake;
  logic                wake_pin;
  logic                stop_go;
  logic                stop_bad;
  logic                deep_ok;
  logic                deep_wake;
  logic                light_wake;
  logic                ack_wr;
  logic                ctrl_wr;

  // Helper functions
  // Mode decoding is shared by entry, regulator and read paths,
  // so it lives in one place to keep those paths consistent.

  // True when the detector keeps the regulator up in stop
  function automatic logic lvd_holds_reg(input logic [7:0] ctrl);
    lvd_holds_reg = ctrl[smc_pkg::SMC_CTRL_LVD_EN]
                    & ctrl[smc_pkg::SMC_CTRL_LVD_STOP_EN];
  endfunction

  // True when a deep request may really enter deep stop
  function automatic logic deep_allowed(input logic [7:0] ctrl,
                                        input logic       dbg);
    deep_allowed = ctrl[smc_pkg::SMC_CTRL_PPD_SEL]
                   & ~dbg
                   & ~lvd_holds_reg(ctrl)
                   & ~ctrl[smc_pkg::SMC_CTRL_LPR];
  endfunction

  // Regulator state for a light stop
  function automatic logic [1:0] light_reg(input logic [7:0] ctrl,
                                           input logic       dbg);
    if (dbg || lvd_holds_reg(ctrl)) begin
      light_reg = smc_pkg::SMC_REG_FULL;
    end else begin
      light_reg = smc_pkg::SMC_REG_STANDBY;
    end
  endfunction

  // Control write; select and low-power run never both set
  function automatic logic [7:0] ctrl_next(input logic [7:0] old_val,
                                           input logic [7:0] new_val);
    logic both;
    ctrl_next = new_val;
    both      = new_val[smc_pkg::SMC_CTRL_PPD_SEL]
                & new_val[smc_pkg::SMC_CTRL_LPR];
    if (both) begin
      // Keep whichever was already set
      ctrl_next[smc_pkg::SMC_CTRL_PPD_SEL] =
        old_val[smc_pkg::SMC_CTRL_PPD_SEL];
      ctrl_next[smc_pkg::SMC_CTRL_LPR] =
        ~old_val[smc_pkg::SMC_CTRL_PPD_SEL];
    end
  endfunction

  // Status word as software reads it
  function automatic logic [7:0] status_word(input logic [1:0] reg_st,
                                             input logic [1:0] st,
                                             input logic       flag);
    status_word = 8'h00;
    status_word[smc_pkg::SMC_STAT_PPD_FLAG] = flag;
    status_word[smc_pkg::SMC_STAT_MODE_HI:smc_pkg::SMC_STAT_MODE_LO] = st;
    status_word[smc_pkg::SMC_STAT_REG_HI:smc_pkg::SMC_STAT_REG_LO] = reg_st;
  endfunction

  // One flag per state keeps the output logic short
  assign in_run   = state_q == smc_pkg::SMC_RUN;
  assign in_light = state_q == smc_pkg::SMC_LIGHT;
  assign in_deep  = state_q == smc_pkg::SMC_DEEP;
  assign in_wake  = state_q == smc_pkg::SMC_WAKE;

  // STOP accepted only in run; bits sampled at that edge
  assign stop_go  = in_run && STOP_EXEC
                    && ctrl_q[smc_pkg::SMC_CTRL_STOP_PERMIT];
  assign stop_bad = in_run && STOP_EXEC
                    && !ctrl_q[smc_pkg::SMC_CTRL_STOP_PERMIT];
  assign deep_ok  = deep_allowed(ctrl_q, DEBUG_MODE_ENABLE);

  // A pin driven high as output is no wake source
  assign wake_pin   = ~WAKE_RESET_PIN_N & ~WAKE_PIN_DRIVEN_HIGH;

  // Deep stop only hears the pin and an enabled time-of-day wake
  assign deep_wake  = wake_pin || (TOD_WAKE
                      && ctrl_q[smc_pkg::SMC_CTRL_TOD_WAKE_EN]);

  // Light stop hears the pin, every interrupt and background
  assign light_wake = wake_pin || IRQ_WAKE || TOD_WAKE
                      || (BACKGROUND_CMD && DEBUG_MODE_ENABLE);

  // Acknowledge and control writes from the register port
  assign ack_wr  = WR && ADDR == smc_pkg::SMC_OFF_ACK
                   && WDATA[smc_pkg::SMC_ACK_PPD];
  assign ctrl_wr = WR && ADDR == smc_pkg::SMC_OFF_CTRL;

  // Control register; kept through both stops
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ctrl_q <= smc_pkg::SMC_CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_q <= ctrl_next(ctrl_q, WDATA);
    end
  end

  // Next stop state from the current one and the wake sources
  always_comb begin
    state_d = state_q;
    case (state_q)
      smc_pkg::SMC_RUN: begin
        if (stop_go) begin
          state_d = deep_ok ? smc_pkg::SMC_DEEP
                            : smc_pkg::SMC_LIGHT;
        end
      end
      smc_pkg::SMC_LIGHT: begin
        if (light_wake) begin
          state_d = smc_pkg::SMC_RUN;
        end
      end
      smc_pkg::SMC_DEEP: begin
        if (deep_wake) begin
          state_d = smc_pkg::SMC_WAKE;
        end
      end
      smc_pkg::SMC_WAKE: begin
        if (!SUPPLY_LOW) begin
          state_d = smc_pkg::SMC_RUN;
        end
      end
      default: begin
        state_d = smc_pkg::SMC_RUN;
      end
    endcase
  end

  // State register
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state_q <= smc_pkg::SMC_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Powerdown flag: set by a deep wake, cleared by acknowledge.
  // Set wins when both fall in one cycle, so no wake is lost.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ppd_flag_q <= 1'b0;
    end else if (in_wake) begin
      ppd_flag_q <= 1'b1;
    end else if (ack_wr) begin
      ppd_flag_q <= 1'b0;
    end
  end

  // Pin latch: closes on deep entry, opens only on acknowledge in run.
  // An early acknowledge while still stopped must not free the pins.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      IO_LATCH <= 1'b0;
    end else if (stop_go && deep_ok) begin
      IO_LATCH <= 1'b1;
    end else if (ack_wr && in_run) begin
      IO_LATCH <= 1'b0;
    end
  end

  // Event outputs
  // Each of these is a one-cycle pulse, launched at the edge that
  // sees its cause; consumers must sample it in the next cycle.
  // A pin wake takes priority over interrupts in light stop.

  // Illegal-opcode reset when STOP runs without permission
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ILLEGAL_OP_RESET <= 1'b0;
    end else begin
      ILLEGAL_OP_RESET <= stop_bad;
    end
  end

  // Reset request when the pin ends light stop
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      PIN_RESET_OUT <= 1'b0;
    end else begin
      PIN_RESET_OUT <= in_light && wake_pin;
    end
  end

  // Interrupt vector when an interrupt ends light stop
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      TAKE_IRQ_VECTOR <= 1'b0;
    end else begin
      TAKE_IRQ_VECTOR <= in_light && !wake_pin
                         && (IRQ_WAKE || TOD_WAKE);
    end
  end

  // Background entry when the debug command ends light stop
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ENTER_BACKGROUND <= 1'b0;
    end else begin
      ENTER_BACKGROUND <= in_light && !wake_pin
                          && BACKGROUND_CMD && DEBUG_MODE_ENABLE;
    end
  end

  // Status commands report an error while stopped
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      STATUS_ERR <= 1'b0;
    end else begin
      STATUS_ERR <= STATUS_CMD && !in_run;
    end
  end

  // Level outputs
  // These follow the state one cycle late and stand until it moves.
  // Debug clocks follow the enable even in run, so a stop entered
  // with debug on finds them already running.

  // Bus and CPU clocks halt in both stops
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      CLK_HALT <= 1'b0;
    end else begin
      CLK_HALT <= in_light || in_deep;
    end
  end

  // Debug logic clocks kept while debug is enabled
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      DEBUG_CLK_RUN <= 1'b0;
    end else begin
      DEBUG_CLK_RUN <= DEBUG_MODE_ENABLE;
    end
  end

  // Most circuitry powered off in deep stop
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      POWERDOWN <= 1'b0;
    end else begin
      POWERDOWN <= in_deep;
    end
  end

  // Power-on style reset while leaving deep stop
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      POR_RESET <= 1'b0;
    end else begin
      POR_RESET <= in_wake;
    end
  end

  // Low-voltage reset armed while leaving deep stop
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      LVR_ENABLE <= 1'b0;
    end else begin
      LVR_ENABLE <= in_wake;
    end
  end

  // Regulator state follows the stop mode
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      REG_STATE <= smc_pkg::SMC_REG_FULL;
    end else begin
      case (state_q)
        smc_pkg::SMC_DEEP: begin
          REG_STATE <= smc_pkg::SMC_REG_PPD;
        end
        smc_pkg::SMC_LIGHT: begin
          REG_STATE <= light_reg(ctrl_q, DEBUG_MODE_ENABLE);
        end
        default: begin
          REG_STATE <= smc_pkg::SMC_REG_FULL;
        end
      endcase
    end
  end

  // Read data one cycle after the read strobe, zero otherwise
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      case (ADDR)
        smc_pkg::SMC_OFF_CTRL: begin
          RDATA <= ctrl_q;
        end
        smc_pkg::SMC_OFF_STATUS: begin
          RDATA <= status_word(REG_STATE, state_q, ppd_flag_q);
        end
        default: begin
          RDATA <= 8'h00;
        end
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

endmodule // smc_stop_ctrl

`default_nettype wire

// *** smc_stop_checker.sv ***
// Checker of stop mode entry and wake-up at the controller ports.
`timescale 1ns/1ps
`default_nettype none
module smc_stop_checker (
  input wire logic       CLOCK,
  input wire logic       RST,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       STOP_EXEC,
  input wire logic       DEBUG_MODE_ENABLE,
  input wire logic       WAKE_RESET_PIN_N,
  input wire logic       WAKE_PIN_DRIVEN_HIGH,
  input wire logic       IRQ_WAKE,
  input wire logic       STATUS_CMD,
  input wire logic       CLK_HALT,
  input wire logic       DEBUG_CLK_RUN,
  input wire logic [1:0] REG_STATE,
  input wire logic       POWERDOWN,
  input wire logic       IO_LATCH,
  input wire logic       ILLEGAL_OP_RESET,
  input wire logic       POR_RESET,
  input wire logic       LVR_ENABLE,
  input wire logic       TAKE_IRQ_VECTOR,
  input wire logic       STATUS_ERR
);
  logic [7:0] ctrl_q;
  logic       go;
  logic       low_voltage_detector;
  // Mirror of the control register
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) ctrl_q <= 8'h00;
    else if (WR && ADDR == smc_pkg::SMC_OFF_CTRL) begin
      ctrl_q <= WDATA;
      // Select and low-power run never both set
      if (WDATA[3] && WDATA[4]) begin
        ctrl_q[3] <= ctrl_q[3];
        ctrl_q[4] <= !ctrl_q[3];
      end
    end
  end
  // Stop request with permit, and regulator kept for the detector
  assign go = STOP_EXEC && ctrl_q[0];
  assign low_voltage_detector = ctrl_q[1] && ctrl_q[2];
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  chk_stop_halt: assert property (go |-> ##[1:4] CLK_HALT)
    else $error("clocks not halted");
  chk_no_permit: assert property (STOP_EXEC && !ctrl_q[0] |->
    ##[1:4] ILLEGAL_OP_RESET && !CLK_HALT) else $error("no illegal reset");
  chk_deep_sel: assert property (go && ctrl_q[3] && !low_voltage_detector &&
    !DEBUG_MODE_ENABLE |-> ##[1:4] POWERDOWN && REG_STATE == 2'h2)
    else $error("deep stop not entered");
  chk_light_sel: assert property (go && !ctrl_q[3] && !low_voltage_detector &&
    !DEBUG_MODE_ENABLE |-> ##[1:4] !POWERDOWN && REG_STATE == 2'h1)
    else $error("light stop not standby");
  chk_debug_full: assert property (go && DEBUG_MODE_ENABLE |->
    ##[1:4] DEBUG_CLK_RUN && !POWERDOWN && REG_STATE == 2'h0)
    else $error("debug stop not full");
  chk_lvd_full: assert property (go && low_voltage_detector && !DEBUG_MODE_ENABLE |->
    ##[1:4] CLK_HALT && !POWERDOWN && REG_STATE == 2'h0)
    else $error("detector stop not full");
  chk_latch_hold: assert property (POWERDOWN |-> IO_LATCH)
    else $error("pins not latched");
  chk_deep_wake: assert property (POWERDOWN && !WAKE_RESET_PIN_N &&
    !WAKE_PIN_DRIVEN_HIGH |-> ##[1:4] POR_RESET && LVR_ENABLE)
    else $error("no reset on deep wake");
  chk_status_err: assert property (CLK_HALT && STATUS_CMD |->
    ##[0:3] STATUS_ERR) else $error("no status error");
  chk_irq_vector: assert property (CLK_HALT && REG_STATE == 2'h1 &&
    IRQ_WAKE |-> ##[1:4] TAKE_IRQ_VECTOR) else $error("no vector");
  // Main scenarios
  cover property (go && ctrl_q[3]);
  cover property (ILLEGAL_OP_RESET);
  cover property (TAKE_IRQ_VECTOR);
endmodule // smc_stop_checker
bind smc_stop_ctrl smc_stop_checker smc_stop_checker_inst (.CLOCK, .RST,
  .ADDR, .WDATA, .WR, .STOP_EXEC, .DEBUG_MODE_ENABLE, .WAKE_RESET_PIN_N,
  .WAKE_PIN_DRIVEN_HIGH, .IRQ_WAKE, .STATUS_CMD, .CLK_HALT, .DEBUG_CLK_RUN,
  .REG_STATE, .POWERDOWN, .IO_LATCH, .ILLEGAL_OP_RESET, .POR_RESET,
  .LVR_ENABLE, .TAKE_IRQ_VECTOR, .STATUS_ERR);
`default_nettype wire

// *** tb_smc_stop_ctrl.sv ***
// Self-checking bench for the stop mode controller.
`timescale 1ns/1ps
`default_nettype none
module tb_smc_stop_ctrl;
  logic CLOCK = 0, RST = 1, WR = 0, RD = 0, STOP_EXEC = 0, SUPPLY_LOW = 0;
  logic DEBUG_MODE_ENABLE = 0, WAKE_RESET_PIN_N = 1, STATUS_CMD = 0;
  logic WAKE_PIN_DRIVEN_HIGH = 0, TOD_WAKE = 0, IRQ_WAKE = 0;
  logic BACKGROUND_CMD = 0, CLK_HALT, DEBUG_CLK_RUN, POWERDOWN, IO_LATCH;
  logic ILLEGAL_OP_RESET, POR_RESET, LVR_ENABLE, PIN_RESET_OUT, STATUS_ERR;
  logic TAKE_IRQ_VECTOR, ENTER_BACKGROUND;
  logic [1:0] REG_STATE;
  logic [3:0] ADDR = 4'h0;
  logic [4:0] ev;
  logic [7:0] WDATA = 8'h00, RDATA;
  logic [7:0] mctl[3] = '{8'h01, 8'h09, 8'h0F}, mst[3] = '{8'h0A, 8'h02, 8'h02};
  logic [7:0] mout[3] = '{8'h09, 8'h18, 8'h08}, mev[3] = '{8'h02, 8'h04, 8'h02};
  logic [2:0] mwk[3] = '{3'h1, 3'h2, 3'h4};
  int errors = 0, checks = 0;
  smc_stop_ctrl smc_stop_ctrl_inst (.CLOCK, .RST, .ADDR, .WDATA, .WR, .RD,
    .RDATA, .STOP_EXEC, .DEBUG_MODE_ENABLE, .WAKE_RESET_PIN_N,
    .WAKE_PIN_DRIVEN_HIGH, .TOD_WAKE, .IRQ_WAKE, .BACKGROUND_CMD, .SUPPLY_LOW,
    .STATUS_CMD, .CLK_HALT, .DEBUG_CLK_RUN, .REG_STATE, .POWERDOWN, .IO_LATCH,
    .ILLEGAL_OP_RESET, .POR_RESET, .LVR_ENABLE, .PIN_RESET_OUT,
    .TAKE_IRQ_VECTOR, .ENTER_BACKGROUND, .STATUS_ERR);
  // Clock of 4 ns
  always #2 CLOCK = ~CLOCK;
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLOCK);
    RD <= 1'b0;
    @(posedge CLOCK);
    chk(n, e, RDATA);
  endtask
  // Steps and gathers the one-cycle pulses
  task automatic run(input int n);
    ev = 5'h00;
    repeat (n) begin
      @(posedge CLOCK);
      ev |= {PIN_RESET_OUT, STATUS_ERR, ENTER_BACKGROUND, TAKE_IRQ_VECTOR,
             ILLEGAL_OP_RESET};
    end
  endtask
  task automatic stop();
    STOP_EXEC <= 1'b1;
    @(posedge CLOCK);
    STOP_EXEC <= 1'b0;
    run(5);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge CLOCK);
    RST <= 1'b0;
    @(posedge CLOCK);
    rd(4'hF, 8'h00, "unmapped");
    wr(4'h0, 8'h00);
    stop();
    chk("illegal", 8'h01, 8'(ev));
    wr(4'h0, 8'h09);
    stop();
    chk("deep", 8'h1E, 8'({CLK_HALT, POWERDOWN, IO_LATCH, REG_STATE}));
    rd(4'h1, 8'h14, "deep status");
    STATUS_CMD <= 1'b1;
    @(posedge CLOCK);
    STATUS_CMD <= 1'b0;
    run(4);
    chk("status err", 8'h08, 8'(ev));
    WAKE_PIN_DRIVEN_HIGH <= 1'b1;
    WAKE_RESET_PIN_N <= 1'b0;
    run(6);
    chk("masked pin", 8'h01, 8'(POWERDOWN));
    SUPPLY_LOW <= 1'b1;
    WAKE_PIN_DRIVEN_HIGH <= 1'b0;
    run(6);
    WAKE_RESET_PIN_N <= 1'b1;
    run(4);
    chk("held", 8'h03, 8'({POR_RESET, LVR_ENABLE}));
    SUPPLY_LOW <= 1'b0;
    run(6);
    chk("restart", 8'h01, 8'({CLK_HALT, POR_RESET, IO_LATCH}));
    rd(4'h1, 8'h01, "flag");
    wr(4'h2, 8'h01);
    run(2);
    chk("latch open", 8'h00, 8'(IO_LATCH));
    rd(4'h1, 8'h00, "flag clear");
    for (int i = 0; i < 3; i++) begin
      DEBUG_MODE_ENABLE <= (i == 1);
      wr(4'h0, mctl[i]);
      stop();
      chk("light", mout[i], 8'({DEBUG_CLK_RUN, CLK_HALT, POWERDOWN, REG_STATE}));
      rd(4'h1, mst[i], "light status");
      {TOD_WAKE, BACKGROUND_CMD, IRQ_WAKE} <= mwk[i];
      @(posedge CLOCK);
      {TOD_WAKE, BACKGROUND_CMD, IRQ_WAKE} <= 3'h0;
      run(5);
      chk("wake", mev[i], 8'({CLK_HALT, ev}));
    end
    DEBUG_MODE_ENABLE <= 1'b0;
    wr(4'h0, 8'h01);
    stop();
    WAKE_RESET_PIN_N <= 1'b0;
    run(3);
    WAKE_RESET_PIN_N <= 1'b1;
    chk("pin exit", 8'h10, 8'({CLK_HALT, ev}));
    wr(4'h0, 8'h29);
    stop();
    TOD_WAKE <= 1'b1;
    @(posedge CLOCK);
    TOD_WAKE <= 1'b0;
    run(4);
    chk("tod wake", 8'h01, 8'({CLK_HALT, POWERDOWN, IO_LATCH}));
    rd(4'h1, 8'h01, "tod flag");
    wr(4'h2, 8'h01);
    run(2);
    chk("tod ack", 8'h00, 8'(IO_LATCH));
    wr(4'h0, 8'h18);
    rd(4'h0, 8'h08, "exclusive");
    wr(4'h0, 8'h10);
    @(posedge CLOCK);
    wr(4'h0, 8'h18);
    rd(4'h0, 8'h10, "exclusive");
    end_sim();
  end
  // Watchdog
  initial begin
    repeat (2000) @(posedge CLOCK);
    errors++;
    end_sim();
  end
endmodule // tb_smc_stop_ctrl
`default_nettype wire
